// [verilog/ocd_pkg.sv]
// ocd_pkg: opcode decoder constants, operation codes and field layout
package ocd_pkg;

  // ------------------------------------------------------------------
  // operations
  // ------------------------------------------------------------------
  typedef enum logic [5:0] {
    OCD_OP_NONE       = 6'h00,
    OCD_OP_ADD        = 6'h01,
    OCD_OP_SUM_CY     = 6'h02,
    OCD_OP_DIFF_BW    = 6'h03,
    OCD_OP_AND        = 6'h04,
    OCD_OP_OR         = 6'h05,
    OCD_OP_XOR        = 6'h06,
    OCD_OP_INC        = 6'h07,
    OCD_OP_DEC        = 6'h08,
    OCD_OP_INC_DP     = 6'h09,
    OCD_OP_MUL        = 6'h0A,
    OCD_OP_DIV        = 6'h0B,
    OCD_OP_DA         = 6'h0C,
    OCD_OP_CLR        = 6'h0D,
    OCD_OP_CPL        = 6'h0E,
    OCD_OP_ROT_L      = 6'h0F,
    OCD_OP_ROT_LC     = 6'h10,
    OCD_OP_ROT_R      = 6'h11,
    OCD_OP_ROT_RC     = 6'h12,
    OCD_OP_SWAP       = 6'h13,
    OCD_OP_MOV        = 6'h14,
    OCD_OP_MOV_DP     = 6'h15,
    OCD_OP_XRAM_RD    = 6'h16,
    OCD_OP_XRAM_WR    = 6'h17,
    OCD_OP_CODE_DP    = 6'h18,
    OCD_OP_CODE_PC    = 6'h19,
    OCD_OP_PUSH       = 6'h1A,
    OCD_OP_POP        = 6'h1B,
    OCD_OP_EXCH       = 6'h1C,
    OCD_OP_EXCH_LO    = 6'h1D
  } ocd_op_e;

  // ------------------------------------------------------------------
  // operand sources and destinations
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    OCD_ARG_NONE  = 3'h0,
    OCD_ARG_ACC   = 3'h1,
    OCD_ARG_BANK  = 3'h2,
    OCD_ARG_DIR   = 3'h3,
    OCD_ARG_IND   = 3'h4,
    OCD_ARG_IMM   = 3'h5,
    OCD_ARG_DIR2  = 3'h6,
    OCD_ARG_OTHER = 3'h7
  } ocd_arg_e;

  // issue sequencer, one-hot
  typedef enum logic [2:0] {
    OCD_ST_IDLE = 3'b001,
    OCD_ST_EXEC = 3'b010,
    OCD_ST_DONE = 3'b100
  } ocd_state_e;

  // ------------------------------------------------------------------
  // field layout of an opcode byte
  // ------------------------------------------------------------------
  localparam int OCD_HI_MSB   = 7;
  localparam int OCD_HI_LSB   = 4;
  localparam int OCD_LO_MSB   = 3;
  localparam int OCD_LO_LSB   = 0;
  localparam int OCD_BANK_BIT = 3;
  localparam int OCD_REG_MSB  = 2;
  localparam int OCD_IND_BIT  = 0;

  localparam logic [3:0] OCD_LO_IMM  = 4'h4;
  localparam logic [3:0] OCD_LO_DIR  = 4'h5;
  localparam logic [3:0] OCD_LO_IND0 = 4'h6;
  localparam logic [3:0] OCD_LO_IND1 = 4'h7;
  localparam logic [3:0] OCD_LO_DA   = 4'h2;
  localparam logic [3:0] OCD_LO_DI   = 4'h3;

  // ------------------------------------------------------------------
  // lengths and cycle counts
  // ------------------------------------------------------------------
  localparam logic [1:0] OCD_LEN_1 = 2'h1;
  localparam logic [1:0] OCD_LEN_2 = 2'h2;
  localparam logic [1:0] OCD_LEN_3 = 2'h3;
  localparam logic [2:0] OCD_CYC_1 = 3'h1;
  localparam logic [2:0] OCD_CYC_2 = 3'h2;
  localparam logic [2:0] OCD_CYC_4 = 3'h4;

  // on-chip expanded ram spans 768 bytes
  localparam logic [15:0] OCD_XRAM_LIMIT = 16'h0300;
  localparam int          OCD_PC_W       = 16;

  // decoded bundle of one opcode
  typedef struct packed {
    ocd_op_e    op;
    ocd_arg_e   dst;
    ocd_arg_e   src;
    logic [2:0] reg_sel;
    logic [1:0] len;
    logic [2:0] cycles;
    logic       valid;
  } ocd_dec_s;

endpackage

// [verilog/ocd_table.sv]
// ocd_table: combinational opcode-to-operation table
`timescale 1ns/1ps
module ocd_table
  import ocd_pkg::*;
(
  // opcode
  input  wire logic [7:0] opcode_in,
  // decoded result
  output ocd_dec_s        dec_out
);

  logic [3:0] hi;
  logic [3:0] lo;
  logic       bank;
  ocd_arg_e   form;

  assign hi   = opcode_in[OCD_HI_MSB:OCD_HI_LSB];
  assign lo   = opcode_in[OCD_LO_MSB:OCD_LO_LSB];
  assign bank = opcode_in[OCD_BANK_BIT];

  // operand form of the regular accumulator-source column group
  always_comb begin
    if (bank) begin
      form = OCD_ARG_BANK;
    end else if (lo == OCD_LO_IMM) begin
      form = OCD_ARG_IMM;
    end else if (lo == OCD_LO_DIR) begin
      form = OCD_ARG_DIR;
    end else if (lo == OCD_LO_IND0 || lo == OCD_LO_IND1) begin
      form = OCD_ARG_IND;
    end else begin
      form = OCD_ARG_NONE;
    end
  end

  always_comb begin
    dec_out         = '0;
    dec_out.op      = OCD_OP_NONE;
    dec_out.dst     = OCD_ARG_NONE;
    dec_out.src     = OCD_ARG_NONE;
    dec_out.len     = OCD_LEN_1;
    dec_out.cycles  = OCD_CYC_1;
    dec_out.reg_sel = bank ? opcode_in[OCD_REG_MSB:OCD_LO_LSB] : {2'h0, opcode_in[OCD_IND_BIT]};
    // regular accumulator column: imm/dir are two bytes
    if (form != OCD_ARG_NONE) begin
      dec_out.valid = 1'b1;
      dec_out.dst   = OCD_ARG_ACC;
      dec_out.src   = form;
      if (form == OCD_ARG_IMM || form == OCD_ARG_DIR) begin
        dec_out.len = OCD_LEN_2;
      end
      unique case (hi)
        4'h2: dec_out.op = OCD_OP_ADD;
        4'h3: dec_out.op = OCD_OP_SUM_CY;
        4'h9: dec_out.op = OCD_OP_DIFF_BW;
        4'h5: dec_out.op = OCD_OP_AND;
        4'h4: dec_out.op = OCD_OP_OR;
        4'h6: dec_out.op = OCD_OP_XOR;
        4'hE: begin
          if (form == OCD_ARG_IMM) begin
            dec_out.op  = OCD_OP_CLR;
            dec_out.src = OCD_ARG_NONE;
            dec_out.len = OCD_LEN_1;
          end else begin
            dec_out.op = OCD_OP_MOV;
          end
        end
        4'hC: begin
          if (form == OCD_ARG_IMM) begin
            dec_out.op  = OCD_OP_SWAP;
            dec_out.src = OCD_ARG_NONE;
            dec_out.len = OCD_LEN_1;
          end else begin
            dec_out.op  = OCD_OP_EXCH;
            dec_out.dst = OCD_ARG_ACC;
          end
        end
        4'h0, 4'h1: begin
          // increment / decrement in place
          dec_out.op  = (hi == 4'h0) ? OCD_OP_INC : OCD_OP_DEC;
          dec_out.dst = (form == OCD_ARG_IMM) ? OCD_ARG_ACC : form;
          dec_out.src = OCD_ARG_NONE;
          dec_out.len = (form == OCD_ARG_DIR) ? OCD_LEN_2 : OCD_LEN_1;
        end
        4'h8: begin
          if (bank) begin
            dec_out.op  = OCD_OP_MOV;
            dec_out.dst = OCD_ARG_DIR;
            dec_out.src = OCD_ARG_BANK;
            dec_out.len = OCD_LEN_2;
            dec_out.cycles = OCD_CYC_2;
          end else if (form == OCD_ARG_DIR) begin
            dec_out.op  = OCD_OP_MOV;
            dec_out.dst = OCD_ARG_DIR2;
            dec_out.src = OCD_ARG_DIR;
            dec_out.len = OCD_LEN_3;
            dec_out.cycles = OCD_CYC_2;
          end else if (form == OCD_ARG_IND) begin
            dec_out.op  = OCD_OP_MOV;
            dec_out.dst = OCD_ARG_DIR;
            dec_out.src = OCD_ARG_IND;
            dec_out.len = OCD_LEN_2;
            dec_out.cycles = OCD_CYC_2;
          end else begin
            dec_out.op  = OCD_OP_DIV;
            dec_out.dst = OCD_ARG_ACC;
            dec_out.src = OCD_ARG_OTHER;
            dec_out.len = OCD_LEN_1;
            dec_out.cycles = OCD_CYC_4;
          end
        end
        4'hA: begin
          if (bank) begin
            dec_out.op  = OCD_OP_MOV;
            dec_out.dst = OCD_ARG_BANK;
            dec_out.src = OCD_ARG_DIR;
            dec_out.len = OCD_LEN_2;
            dec_out.cycles = OCD_CYC_2;
          end else if (form == OCD_ARG_IND) begin
            dec_out.op  = OCD_OP_MOV;
            dec_out.dst = OCD_ARG_IND;
            dec_out.src = OCD_ARG_DIR;
            dec_out.len = OCD_LEN_2;
            dec_out.cycles = OCD_CYC_2;
          end else if (form == OCD_ARG_IMM) begin
            dec_out.op  = OCD_OP_MUL;
            dec_out.src = OCD_ARG_OTHER;
            dec_out.len = OCD_LEN_1;
            dec_out.cycles = OCD_CYC_4;
          end else begin
            dec_out.valid = 1'b0;
          end
        end
        4'h7: begin
          // immediate into acc, direct, indirect or bank register
          dec_out.src = OCD_ARG_IMM;
          dec_out.op  = OCD_OP_MOV;
          if (form == OCD_ARG_IMM) begin
            dec_out.dst = OCD_ARG_ACC;
          end else if (form == OCD_ARG_DIR) begin
            dec_out.dst = OCD_ARG_DIR;
            dec_out.len = OCD_LEN_3;
            dec_out.cycles = OCD_CYC_2;
          end else begin
            dec_out.dst = form;
            dec_out.len = OCD_LEN_2;
          end
        end
        4'hF: begin
          if (form == OCD_ARG_IMM) begin
            dec_out.op  = OCD_OP_CPL;
            dec_out.src = OCD_ARG_NONE;
            dec_out.len = OCD_LEN_1;
          end else begin
            dec_out.op  = OCD_OP_MOV;
            dec_out.dst = form;
            dec_out.src = OCD_ARG_ACC;
          end
        end
        4'hD: begin
          if (form == OCD_ARG_IND) begin
            dec_out.op = OCD_OP_EXCH_LO;
          end else if (form == OCD_ARG_IMM) begin
            dec_out.op  = OCD_OP_DA;
            dec_out.src = OCD_ARG_NONE;
            dec_out.len = OCD_LEN_1;
          end else begin
            dec_out.valid = 1'b0;
          end
        end
        default: dec_out.valid = 1'b0;
      endcase
    end else begin
      // columns 0..3: rotates, logic-to-direct, transfers
      dec_out.valid = 1'b1;
      dec_out.dst   = OCD_ARG_ACC;
      unique case (opcode_in)
        8'h23: dec_out.op = OCD_OP_ROT_L;
        8'h33: dec_out.op = OCD_OP_ROT_LC;
        8'h03: dec_out.op = OCD_OP_ROT_R;
        8'h13: dec_out.op = OCD_OP_ROT_RC;
        8'h52, 8'h42, 8'h62, 8'h53, 8'h43, 8'h63: begin
          dec_out.op  = (hi == 4'h5) ? OCD_OP_AND : (hi == 4'h4) ? OCD_OP_OR : OCD_OP_XOR;
          dec_out.dst = OCD_ARG_DIR;
          if (lo == OCD_LO_DA) begin
            dec_out.src = OCD_ARG_ACC;
            dec_out.len = OCD_LEN_2;
          end else begin
            dec_out.src    = OCD_ARG_IMM;
            dec_out.len    = OCD_LEN_3;
            dec_out.cycles = OCD_CYC_2;
          end
        end
        8'h90: begin
          dec_out.op = OCD_OP_MOV_DP;
          dec_out.dst = OCD_ARG_OTHER;
          dec_out.src = OCD_ARG_IMM;
          dec_out.len = OCD_LEN_3;
          dec_out.cycles = OCD_CYC_2;
        end
        8'hA3: begin
          dec_out.op = OCD_OP_INC_DP;
          dec_out.dst = OCD_ARG_OTHER;
          dec_out.cycles = OCD_CYC_2;
        end
        8'hE2, 8'hE3, 8'hE0: begin
          dec_out.op  = OCD_OP_XRAM_RD;
          dec_out.src = (lo == 4'h0) ? OCD_ARG_OTHER : OCD_ARG_IND;
          dec_out.cycles = OCD_CYC_2;
        end
        8'hF2, 8'hF3, 8'hF0: begin
          dec_out.op  = OCD_OP_XRAM_WR;
          dec_out.dst = (lo == 4'h0) ? OCD_ARG_OTHER : OCD_ARG_IND;
          dec_out.src = OCD_ARG_ACC;
          dec_out.cycles = OCD_CYC_2;
        end
        8'h93, 8'h83: begin
          dec_out.op  = (opcode_in == 8'h93) ? OCD_OP_CODE_DP : OCD_OP_CODE_PC;
          dec_out.src = OCD_ARG_OTHER;
          dec_out.cycles = OCD_CYC_2;
        end
        8'hC0, 8'hD0: begin
          dec_out.op  = (opcode_in == 8'hC0) ? OCD_OP_PUSH : OCD_OP_POP;
          dec_out.dst = (opcode_in == 8'hC0) ? OCD_ARG_OTHER : OCD_ARG_DIR;
          dec_out.src = (opcode_in == 8'hC0) ? OCD_ARG_DIR : OCD_ARG_OTHER;
          dec_out.len = OCD_LEN_2;
          dec_out.cycles = OCD_CYC_2;
        end
        default: dec_out.valid = 1'b0;
      endcase
    end
    // unknown codes step one byte so the fetch side cannot lose sync
    if (!dec_out.valid) begin
      dec_out.len    = OCD_LEN_1;
      dec_out.cycles = OCD_CYC_1;
    end
  end

endmodule // ocd_table

// [verilog/ocd_decoder.sv]
// ocd_decoder: opcode decode, issue pacing and external ram routing
// ------------------------------------------------------------------
// Function
// - opcodes match the standard 8-bit core encoding and function
// - add: bank 28-2F, direct 25, indirect 26-27, immediate 24; one cycle
// - add with carry: 38-3F, 35, 36-37, 34; one cycle
// - subtract with borrow: 98-9F, 95, 96-97, 94; one cycle
// - and into acc: 58-5F, 55, 56-57, 54; one cycle
// - or into acc: 48-4F, 45, 46-47, 44; one cycle
// - xor into acc: 68-6F, 65, 66-67, 64; one cycle
// - logic to direct: 52/42/62 two bytes one cycle; 53/43/63 three bytes two
// - rotates 23 left, 33 left carry, 03 right, 13 right carry
// - C4 swaps accumulator nibbles, one byte one cycle
// - move into acc: E8-EF, E5, E6-E7, immediate 74; one cycle
// - A8-AF and 88-8F are two bytes, two cycles
// - 85 copies direct to direct, three bytes, two cycles
// - 75 writes immediate to direct, three bytes, two cycles
// - 90 loads data pointer with 16-bit immediate, three bytes two cycles
// - external ram via pointer register: E2-E3 read, F2-F3 write
// - external ram via data pointer: E0 read, F0 write; two cycles
// - 93 code byte at acc+data pointer, 83 at acc+pc; two cycles
// - push C0 and pop D0 are two bytes, two cycles
// - exchange C8-CF, C5, C6-C7; D6-D7 swaps low nibble only
// - A6-A7 and 86-87 are two bytes, two cycles
// - expanded ram disabled sends every external transfer off-chip
// ------------------------------------------------------------------
`timescale 1ns/1ps
module ocd_decoder
  import ocd_pkg::*;
(
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  // opcode fetch
  input  wire logic                opcode_valid_in,
  input  wire logic [7:0]          opcode_in,
  output logic                     opcode_ready_out,
  // external ram routing inputs
  input  wire logic                onchip_xram_enable_in,
  input  wire logic [15:0]         xram_addr_in,
  // decoded instruction
  output logic                     issue_out,
  output ocd_op_e                  op_out,
  output ocd_arg_e                 dst_out,
  output ocd_arg_e                 src_out,
  output logic [2:0]               reg_sel_out,
  output logic [1:0]               len_out,
  output logic [2:0]               cycles_out,
  output logic                     illegal_out,
  output logic                     xram_offchip_out,
  output logic [OCD_PC_W-1:0]      pc_out,
  output logic                     busy_out
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    ocd_state_e          st;
    logic [2:0]          cnt;
    logic [OCD_PC_W-1:0] pc;
    ocd_dec_s            dec;
    logic                issue;
    logic                illegal;
    logic                offchip;
  } ocd_state_s;

  ocd_state_s s_q;
  ocd_state_s s_d;
  ocd_dec_s   dec_w;

  ocd_table u_table (
    .opcode_in (opcode_in),
    .dec_out   (dec_w)
  );

  // only accepted while no instruction is still executing
  assign opcode_ready_out = (s_q.st == OCD_ST_IDLE);

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.issue = 1'b0;
    unique case (s_q.st)
      OCD_ST_IDLE: begin
        if (opcode_valid_in) begin
          s_d.dec     = dec_w;
          s_d.issue   = 1'b1;
          s_d.illegal = ~dec_w.valid;
          // unknown opcodes advance one byte so the core cannot stall
          s_d.pc  = s_q.pc + {{(OCD_PC_W-2){1'b0}}, dec_w.len};
          // expanded ram only below its limit and only when enabled
          s_d.offchip = (dec_w.op == OCD_OP_XRAM_RD || dec_w.op == OCD_OP_XRAM_WR) &&
                        (~onchip_xram_enable_in || xram_addr_in >= OCD_XRAM_LIMIT);
          s_d.cnt = dec_w.cycles - OCD_CYC_1;
          s_d.st  = (dec_w.cycles > OCD_CYC_1) ? OCD_ST_EXEC : OCD_ST_DONE;
        end
      end
      OCD_ST_EXEC: begin
        s_d.cnt = s_q.cnt - OCD_CYC_1;
        if (s_q.cnt == OCD_CYC_1) begin
          s_d.st = OCD_ST_DONE;
        end
      end
      OCD_ST_DONE: begin
        s_d.st = OCD_ST_IDLE;
      end
      default: s_d.st = OCD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q    <= '0;
      s_q.st <= OCD_ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign issue_out        = s_q.issue;
  assign op_out           = s_q.dec.op;
  assign dst_out          = s_q.dec.dst;
  assign src_out          = s_q.dec.src;
  assign reg_sel_out      = s_q.dec.reg_sel;
  assign len_out          = s_q.dec.len;
  assign cycles_out       = s_q.dec.cycles;
  assign illegal_out      = s_q.illegal;
  assign xram_offchip_out = s_q.offchip;
  assign pc_out           = s_q.pc;
  assign busy_out         = (s_q.st != OCD_ST_IDLE);

endmodule // ocd_decoder

// [testbench/ocd_decoder_props.sv]
// ocd_decoder_props: port-level assertions for the opcode decoder
`timescale 1ns/1ps
module ocd_decoder_props
  import ocd_pkg::*;
(
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  // fetch side
  input wire logic        opcode_valid_in,
  input wire logic [7:0]  opcode_in,
  input wire logic        opcode_ready_out,
  input wire logic        onchip_xram_enable_in,
  input wire logic [15:0] xram_addr_in,
  // decoded side
  input wire logic        issue_out,
  input ocd_op_e          op_out,
  input ocd_arg_e         dst_out,
  input ocd_arg_e         src_out,
  input wire logic [2:0]  reg_sel_out,
  input wire logic [1:0]  len_out,
  input wire logic [2:0]  cycles_out,
  input wire logic        illegal_out,
  input wire logic        xram_offchip_out,
  input wire logic [15:0] pc_out,
  input wire logic        busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic take;
  assign take = opcode_valid_in && opcode_ready_out;

  // ------------------------------------------------------------------
  // pacing and program counter
  // ------------------------------------------------------------------
  AST_TAKE_ISSUE: assert property (take |=> issue_out) else $error("no issue after take");
  AST_NO_SPURIOUS: assert property (!take |=> !issue_out) else $error("issue without take");
  AST_PULSE: assert property (issue_out |=> !issue_out) else $error("issue longer than one cycle");
  AST_PC_STEP: assert property (issue_out |-> pc_out == $past(pc_out) + 16'(len_out))
    else $error("pc did not advance by length");
  AST_HOLD: assert property (!issue_out |-> $stable({pc_out, op_out, len_out, cycles_out}))
    else $error("fields moved without issue");
  AST_SPAN_ONE: assert property (issue_out && cycles_out == OCD_CYC_1 |-> !opcode_ready_out ##1 opcode_ready_out)
    else $error("one-cycle op refused wrong span");
  AST_SPAN_TWO: assert property (issue_out && cycles_out == OCD_CYC_2 |-> !opcode_ready_out [*2] ##1 opcode_ready_out)
    else $error("two-cycle op refused wrong span");
  // ------------------------------------------------------------------
  // decode spot checks and routing
  // ------------------------------------------------------------------
  AST_ADD_IMM: assert property (take && opcode_in == 8'h24 |=> op_out == OCD_OP_ADD && len_out == OCD_LEN_2)
    else $error("immediate add decoded wrong");
  AST_MOVE_DIR: assert property (take && opcode_in == 8'h85 |=> len_out == OCD_LEN_3 && cycles_out == OCD_CYC_2)
    else $error("direct copy decoded wrong");
  AST_XRAM_OFF: assert property (take && !onchip_xram_enable_in &&
    opcode_in inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3} |=> xram_offchip_out)
    else $error("disabled ram not routed off-chip");
  AST_OFF_ONLY_XRAM: assert property (xram_offchip_out |-> op_out inside {OCD_OP_XRAM_RD, OCD_OP_XRAM_WR})
    else $error("off-chip flag on non-external op");

  COV_OFF: cover property (issue_out && xram_offchip_out);
  COV_TWO: cover property (issue_out && cycles_out == OCD_CYC_2);
  COV_ILL: cover property (issue_out && illegal_out);
endmodule // ocd_decoder_props

// [testbench/tb_ocd_decoder.sv]
// tb_ocd_decoder: self-checking bench for the opcode decoder
`timescale 1ns/1ps
module tb_ocd_decoder
  import ocd_pkg::*;
;
  logic        clk_in, rst_n_in, opcode_valid_in, opcode_ready_out, xen, issue_out;
  logic [7:0]  opcode_in;
  logic [15:0] xaddr, pc_out, exp_pc;
  ocd_op_e     op_out;
  logic [1:0]  len_out;
  logic [2:0]  cycles_out, reg_sel_out;
  logic        illegal_out, xram_offchip_out, busy_out;
  int          n_mismatch, comparisons, hits;
  logic [7:0]  c;

  ocd_decoder u_ocd_decoder (.clk_in(clk_in), .rst_n_in(rst_n_in), .opcode_valid_in(opcode_valid_in),
    .opcode_in(opcode_in), .opcode_ready_out(opcode_ready_out), .onchip_xram_enable_in(xen),
    .xram_addr_in(xaddr), .issue_out(issue_out), .op_out(op_out), .dst_out(), .src_out(), .reg_sel_out(reg_sel_out),
    .len_out(len_out), .cycles_out(cycles_out), .illegal_out(illegal_out),
    .xram_offchip_out(xram_offchip_out), .pc_out(pc_out), .busy_out(busy_out));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    comparisons++;
    if (s !== x) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [11:0] pk(input ocd_op_e o, input logic [1:0] l, input logic [2:0] y);
    return {1'b1, o, l, y};
  endfunction

  // expected {known, op, length, cycles}; zero marks codes this bench sends only as bad codes or not at all
  function automatic logic [11:0] ref_dec(input logic [7:0] b);
    ocd_op_e o;
    case (b[7:4])
      4'h2: o = OCD_OP_ADD;
      4'h3: o = OCD_OP_SUM_CY;
      4'h9: o = OCD_OP_DIFF_BW;
      4'h5: o = OCD_OP_AND;
      4'h4: o = OCD_OP_OR;
      4'h6: o = OCD_OP_XOR;
      default: o = OCD_OP_NONE;
    endcase
    if (o != OCD_OP_NONE && b[3:0] >= 4'h4)
      return pk(o, (b[3:1] == 3'h2) ? OCD_LEN_2 : OCD_LEN_1, OCD_CYC_1);
    if (o inside {OCD_OP_AND, OCD_OP_OR, OCD_OP_XOR} && b[3:1] == 3'h1)
      return b[0] ? pk(o, OCD_LEN_3, OCD_CYC_2) : pk(o, OCD_LEN_2, OCD_CYC_1);
    case (b[7:3])
      5'h1D: return pk(OCD_OP_MOV, OCD_LEN_1, OCD_CYC_1);
      5'h15, 5'h11: return pk(OCD_OP_MOV, OCD_LEN_2, OCD_CYC_2);
      5'h19: return pk(OCD_OP_EXCH, OCD_LEN_1, OCD_CYC_1);
      default: ;
    endcase
    case (b)
      8'h23: return pk(OCD_OP_ROT_L, OCD_LEN_1, OCD_CYC_1);
      8'h33: return pk(OCD_OP_ROT_LC, OCD_LEN_1, OCD_CYC_1);
      8'h03: return pk(OCD_OP_ROT_R, OCD_LEN_1, OCD_CYC_1);
      8'h13: return pk(OCD_OP_ROT_RC, OCD_LEN_1, OCD_CYC_1);
      8'hC4: return pk(OCD_OP_SWAP, OCD_LEN_1, OCD_CYC_1);
      8'hE4: return pk(OCD_OP_CLR, OCD_LEN_1, OCD_CYC_1);
      8'hD4: return pk(OCD_OP_DA, OCD_LEN_1, OCD_CYC_1);
      8'hA4: return pk(OCD_OP_MUL, OCD_LEN_1, OCD_CYC_4);
      8'hE6, 8'hE7: return pk(OCD_OP_MOV, OCD_LEN_1, OCD_CYC_1);
      8'hE5, 8'h74: return pk(OCD_OP_MOV, OCD_LEN_2, OCD_CYC_1);
      8'h85, 8'h75: return pk(OCD_OP_MOV, OCD_LEN_3, OCD_CYC_2);
      8'h90: return pk(OCD_OP_MOV_DP, OCD_LEN_3, OCD_CYC_2);
      8'hE0, 8'hE2, 8'hE3: return pk(OCD_OP_XRAM_RD, OCD_LEN_1, OCD_CYC_2);
      8'hF0, 8'hF2, 8'hF3: return pk(OCD_OP_XRAM_WR, OCD_LEN_1, OCD_CYC_2);
      8'h93: return pk(OCD_OP_CODE_DP, OCD_LEN_1, OCD_CYC_2);
      8'h83: return pk(OCD_OP_CODE_PC, OCD_LEN_1, OCD_CYC_2);
      8'hC0: return pk(OCD_OP_PUSH, OCD_LEN_2, OCD_CYC_2);
      8'hD0: return pk(OCD_OP_POP, OCD_LEN_2, OCD_CYC_2);
      8'hC5: return pk(OCD_OP_EXCH, OCD_LEN_2, OCD_CYC_1);
      8'hC6, 8'hC7: return pk(OCD_OP_EXCH, OCD_LEN_1, OCD_CYC_1);
      8'hD6, 8'hD7: return pk(OCD_OP_EXCH_LO, OCD_LEN_1, OCD_CYC_1);
      8'hA6, 8'hA7, 8'h86, 8'h87: return pk(OCD_OP_MOV, OCD_LEN_2, OCD_CYC_2);
      default: return 12'h000;
    endcase
  endfunction

  // one full transfer; bad marks a code outside the table
  task automatic send(input logic [7:0] b, input logic en, input logic [15:0] a, input logic bad);
    logic [11:0] e;
    logic        off;
    int          n;
    e = bad ? 12'h009 : ref_dec(b);
    off = (e[10:5] == OCD_OP_XRAM_RD || e[10:5] == OCD_OP_XRAM_WR) && (!en || a >= OCD_XRAM_LIMIT);
    @(posedge clk_in);
    opcode_valid_in <= 1'b1;
    opcode_in <= b;
    xen <= en;
    xaddr <= a;
    n = 0;
    @(negedge clk_in);
    while (opcode_ready_out !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 20) begin
      n_mismatch++;
      tally_and_finish();
    end
    @(posedge clk_in);
    opcode_valid_in <= 1'b0;
    @(negedge clk_in);
    exp_pc = exp_pc + 16'(e[4:3]);
    chk(issue_out, 1'b1);
    chk(busy_out, 1'b1);
    if (b[3] && !bad) chk(reg_sel_out, 16'(b[2:0]));
    if (!bad) chk(op_out, e[10:5]);
    chk(len_out, e[4:3]);
    chk(cycles_out, e[2:0]);
    chk(illegal_out, bad);
    chk(xram_offchip_out, off);
    chk(pc_out, exp_pc);
    n = 0;
    while (opcode_ready_out !== 1'b1 && n < 10) begin
      n++;
      @(negedge clk_in);
    end
    if (n >= 10) begin
      n_mismatch++;
      tally_and_finish();
    end
    chk(16'(n), 16'(e[2:0]));
    chk(busy_out, 1'b0);
  endtask

  initial begin
    repeat (100000) @(posedge clk_in);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    rst_n_in = 1'b0;
    opcode_valid_in = 1'b0;
    opcode_in = 8'h00;
    xen = 1'b1;
    xaddr = 16'h0000;
    exp_pc = 16'h0000;
    n_mismatch = 0;
    comparisons = 0;
    void'($urandom(38751));
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(negedge clk_in);
    chk(pc_out, 16'h0000);
    chk(opcode_ready_out, 1'b1);
    $display("test reset done");
    // ------------------------------------------------------------------
    // every listed code once, then routing corners and illegal codes
    // ------------------------------------------------------------------
    for (int i = 0; i < 256; i++)
      if (ref_dec(8'(i)) != 12'h000) send(8'(i), 1'($urandom_range(0, 3) != 0), 16'($urandom), 1'b0);
    send(8'hE0, 1'b0, 16'h0000, 1'b0);
    send(8'hF0, 1'b1, 16'h02FF, 1'b0);
    send(8'hE2, 1'b1, 16'h0300, 1'b0);
    send(8'hB4, 1'b1, 16'h0000, 1'b1);
    send(8'hD8, 1'b1, 16'h0000, 1'b1);
    send(8'h12, 1'b1, 16'h0000, 1'b1);
    send(8'h80, 1'b0, 16'h0400, 1'b1);
    $display("test sweep done");
    // ------------------------------------------------------------------
    // random codes and addresses
    // ------------------------------------------------------------------
    for (int i = 0; i < 80; i++) begin
      c = 8'($urandom);
      for (int j = 0; j < 64 && ref_dec(c) == 12'h000; j++)
        c = 8'($urandom);
      if (ref_dec(c) != 12'h000)
        send(c, 1'($urandom_range(0, 3) != 0), ($urandom_range(0, 2) == 0) ? 16'h02FF : 16'($urandom), 1'b0);
    end
    $display("test random done");
    // ------------------------------------------------------------------
    // request held through the busy span is taken every third edge
    // ------------------------------------------------------------------
    @(posedge clk_in);
    opcode_valid_in <= 1'b1;
    opcode_in <= 8'h85;
    hits = 0;
    repeat (8) begin
      @(negedge clk_in);
      if (issue_out === 1'b1) hits++;
    end
    @(posedge clk_in);
    opcode_valid_in <= 1'b0;
    repeat (3) @(negedge clk_in);
    exp_pc = exp_pc + 16'h0009;
    chk(16'(hits), 16'h0003);
    chk(pc_out, exp_pc);
    $display("test refusal done");
    // ------------------------------------------------------------------
    // reset in mid-run
    // ------------------------------------------------------------------
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    @(negedge clk_in);
    chk(pc_out, 16'h0000);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    exp_pc = 16'h0000;
    send(8'h90, 1'b1, 16'h0000, 1'b0);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule // tb_ocd_decoder

bind ocd_decoder ocd_decoder_props u_ocd_decoder_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .opcode_valid_in(opcode_valid_in), .opcode_in(opcode_in), .opcode_ready_out(opcode_ready_out),
  .onchip_xram_enable_in(onchip_xram_enable_in), .xram_addr_in(xram_addr_in), .issue_out(issue_out),
  .op_out(op_out), .dst_out(dst_out), .src_out(src_out), .reg_sel_out(reg_sel_out), .len_out(len_out),
  .cycles_out(cycles_out), .illegal_out(illegal_out), .xram_offchip_out(xram_offchip_out), .pc_out(pc_out),
  .busy_out(busy_out));
